// ===== include/mie_pkg.sv
/*
 * Package for the instruction execution subset: operation codes, flag
 * layout, reset values and timing counts.
 * Assumes a single 50 MHz clock and a decoder that presents one operation
 * at a time together with its operands.
 */
package mie_pkg;

    // ****************************************
    // Operation codes
    // ****************************************
    typedef enum logic [4:0] {
        MIE_NOP        = 5'h00,
        MIE_ADC_ACC    = 5'h01,
        MIE_ADC_MEM    = 5'h02,
        MIE_ADD_ACC    = 5'h03,
        MIE_ADD_IMM    = 5'h04,
        MIE_ADD_MEM    = 5'h05,
        MIE_AND_ACC    = 5'h06,
        MIE_AND_IMM    = 5'h07,
        MIE_AND_MEM    = 5'h08,
        MIE_CALL       = 5'h09,
        MIE_CLR_BYTE   = 5'h0a,
        MIE_CLR_BIT    = 5'h0b,
        MIE_WDT_CLR    = 5'h0c,
        MIE_WDT_PRE1   = 5'h0d,
        MIE_WDT_PRE2   = 5'h0e,
        MIE_CPL_MEM    = 5'h0f,
        MIE_CPL_ACC    = 5'h10,
        MIE_DAA        = 5'h11,
        MIE_DEC_MEM    = 5'h12,
        MIE_DEC_ACC    = 5'h13,
        MIE_HALT       = 5'h14,
        MIE_INC_MEM    = 5'h15,
        MIE_INC_ACC    = 5'h16,
        MIE_JMP        = 5'h17
    } mie_op_t;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        MIE_ST_IDLE  = 3'b001,
        MIE_ST_EXEC  = 3'b010,
        MIE_ST_SLEEP = 3'b100
    } mie_state_t;

    // Request from the decoder
    typedef struct packed {
        mie_op_t     op;
        logic [7:0]  mem;
        logic [7:0]  imm;
        logic [2:0]  bit_sel;
        logic [10:0] target;
        logic        pcl_dest;
    } mie_req_t;

    // Status flags
    typedef struct packed {
        logic ovf;
        logic zero;
        logic half;
        logic carry;
    } mie_flags_t;

    localparam int         MIE_PC_W      = 11;
    localparam logic [7:0] MIE_BYTE_ZERO = 8'h00;
    localparam logic [7:0] MIE_BYTE_ONE  = 8'h01;
    localparam logic [3:0] MIE_BCD_MAX   = 4'h9;
    localparam logic [3:0] MIE_BCD_FIX   = 4'h6;
    localparam logic [MIE_PC_W-1:0] MIE_PC_RST = 11'h000;
    localparam logic [MIE_PC_W-1:0] MIE_PC_ONE = 11'h001;
    localparam int         MIE_WDT_W     = 8;
    localparam int         MIE_PRE_W     = 8;
    // Instruction cycle in system clocks, and the extra one on a PROGRAM_COUNTER_LOW_BYTE write
    localparam int         MIE_CLK_PER_NS   = 20;
    localparam int         MIE_ICYC_NS      = 80;
    localparam int         MIE_ICYC_CLKS    = MIE_ICYC_NS / MIE_CLK_PER_NS;
    localparam logic [3:0] MIE_ICYC_CNT     = 4'(MIE_ICYC_CLKS);
    localparam logic [3:0] MIE_ICYC_CNT2    = 4'(2 * MIE_ICYC_CLKS);

endpackage

// ===== design/mie_core.sv
/*
 * Execution unit for a subset of an 8-bit microcontroller instruction set.
 * Takes one decoded operation with its memory operand, computes results
 * and flags, writes back, and paces each instruction in system clocks.
 * Assumes the decoder waits for ready_out before issuing the next request
 * and that memory/stack writes are performed by the caller on the strobes.
 */
`timescale 1ns/100ps
module mie_core (
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    input  wire logic             req_valid_in,
    input  wire mie_pkg::mie_req_t req_in,
    input  wire logic             wdt_tick_in,
    input  wire logic             wake_in,
    output logic                  ready_out,
    output logic [7:0]            acc_out,
    output mie_pkg::mie_flags_t   flags_out,
    output logic                  mem_we_out,
    output logic [7:0]            mem_wdata_out,
    output logic                  push_out,
    output logic [10:0]           push_data_out,
    output logic [10:0]           pc_out,
    output logic                  sleep_flag_out,
    output logic                  expired_flag_out,
    output logic [7:0]            wdt_count_out,
    output logic                  clk_gate_out
);

    // ****************************************
    // Registers
    // ****************************************
    mie_pkg::mie_state_t state_r, state_nxt;
    logic [3:0]          cnt_r, cnt_nxt;
    logic [7:0]          acc_r, acc_nxt;
    mie_pkg::mie_flags_t flg_r, flg_nxt;
    logic                we_r, we_nxt;
    logic [7:0]          wd_r, wd_nxt;
    logic                push_r, push_nxt;
    logic [10:0]         pdat_r, pdat_nxt;
    logic [10:0]         pc_r, pc_nxt;
    logic                pdf_r, pdf_nxt;
    logic                to_r, to_nxt;
    logic [7:0]          wdt_r, wdt_nxt;
    logic [7:0]          pre_r, pre_nxt;
    logic                pre1_r, pre1_nxt;
    logic                pre2_r, pre2_nxt;
    logic                gate_r, gate_nxt;

    // ****************************************
    // Datapath
    // ****************************************
    logic [8:0] sum9;
    logic [4:0] lo5;
    logic       ovf;
    logic [7:0] addend;
    logic       cin;
    logic [7:0] res;
    logic [4:0] daa_lo;
    logic [4:0] daa_hi;
    logic       ac1;
    logic       daa_c;
    logic [7:0] bit_mask;

    always_comb begin
        addend = (req_in.op == mie_pkg::MIE_ADD_IMM ||
                  req_in.op == mie_pkg::MIE_AND_IMM) ? req_in.imm
                                                     : req_in.mem;
        cin = ((req_in.op == mie_pkg::MIE_ADC_ACC) ||
               (req_in.op == mie_pkg::MIE_ADC_MEM)) ? flg_r.carry : 1'b0;
        sum9 = {1'b0, acc_r} + {1'b0, addend} + {8'h00, cin};
        lo5  = {1'b0, acc_r[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        ovf  = (acc_r[7] == addend[7]) && (sum9[7] != acc_r[7]);
        bit_mask = ~(mie_pkg::MIE_BYTE_ONE << req_in.bit_sel);
        // Decimal adjust of the working register
        if ((acc_r[3:0] > mie_pkg::MIE_BCD_MAX) || flg_r.half) begin
            daa_lo = {1'b0, acc_r[3:0]} + {1'b0, mie_pkg::MIE_BCD_FIX};
            ac1    = daa_lo[4];
        end else begin
            daa_lo = {1'b0, acc_r[3:0]};
            ac1    = 1'b0;
        end
        daa_hi = {1'b0, acc_r[7:4]} + {4'h0, ac1};
        if ((daa_hi > {1'b0, mie_pkg::MIE_BCD_MAX}) || flg_r.carry) begin
            daa_hi = daa_hi + {1'b0, mie_pkg::MIE_BCD_FIX};
            daa_c  = 1'b1;
        end else begin
            daa_c  = flg_r.carry;
        end
        case (req_in.op)
            mie_pkg::MIE_AND_ACC,
            mie_pkg::MIE_AND_IMM,
            mie_pkg::MIE_AND_MEM: res = acc_r & addend;
            mie_pkg::MIE_CLR_BYTE: res = mie_pkg::MIE_BYTE_ZERO;
            mie_pkg::MIE_CLR_BIT:  res = req_in.mem & bit_mask;
            mie_pkg::MIE_CPL_MEM,
            mie_pkg::MIE_CPL_ACC:  res = ~req_in.mem;
            mie_pkg::MIE_DEC_MEM,
            mie_pkg::MIE_DEC_ACC:  res = req_in.mem - mie_pkg::MIE_BYTE_ONE;
            mie_pkg::MIE_INC_MEM,
            mie_pkg::MIE_INC_ACC:  res = req_in.mem + mie_pkg::MIE_BYTE_ONE;
            mie_pkg::MIE_DAA:      res = {daa_hi[3:0], daa_lo[3:0]};
            default:               res = sum9[7:0];
        endcase
    end

    // ****************************************
    // Sequencer and state update
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        acc_nxt   = acc_r;
        flg_nxt   = flg_r;
        we_nxt    = 1'b0;
        wd_nxt    = wd_r;
        push_nxt  = 1'b0;
        pdat_nxt  = pdat_r;
        pc_nxt    = pc_r;
        pdf_nxt   = pdf_r;
        to_nxt    = to_r;
        wdt_nxt   = wdt_r;
        pre_nxt   = pre_r;
        pre1_nxt  = pre1_r;
        pre2_nxt  = pre2_r;
        gate_nxt  = gate_r;
        // Watchdog counts ticks except in sleep; timeout sets expired flag
        if (state_r != mie_pkg::MIE_ST_SLEEP && wdt_tick_in) begin
            {pre_nxt} = pre_r + 8'h01;
            if (pre_r == 8'hff) begin
                wdt_nxt = wdt_r + 8'h01;
                if (wdt_r == 8'hff) begin
                    to_nxt = 1'b1;
                end
            end
        end
        case (state_r)
            mie_pkg::MIE_ST_IDLE: begin
                if (req_valid_in) begin
                    state_nxt = mie_pkg::MIE_ST_EXEC;
                    // Two-cycle and PROGRAM_COUNTER_LOW_BYTE-writing instructions run longer
                    cnt_nxt = (req_in.pcl_dest ||
                               req_in.op == mie_pkg::MIE_CALL ||
                               req_in.op == mie_pkg::MIE_JMP)
                              ? mie_pkg::MIE_ICYC_CNT2 - 4'h1
                              : mie_pkg::MIE_ICYC_CNT - 4'h1;
                    pc_nxt = pc_r + mie_pkg::MIE_PC_ONE;
                    case (req_in.op)
                        mie_pkg::MIE_ADC_ACC, mie_pkg::MIE_ADD_ACC,
                        mie_pkg::MIE_ADD_IMM: begin
                            acc_nxt = res;
                            flg_nxt = '{ovf, res == 8'h00, lo5[4], sum9[8]};
                        end
                        mie_pkg::MIE_ADC_MEM, mie_pkg::MIE_ADD_MEM: begin
                            we_nxt  = 1'b1;
                            wd_nxt  = res;
                            flg_nxt = '{ovf, res == 8'h00, lo5[4], sum9[8]};
                        end
                        mie_pkg::MIE_AND_ACC, mie_pkg::MIE_AND_IMM,
                        mie_pkg::MIE_CPL_ACC, mie_pkg::MIE_DEC_ACC,
                        mie_pkg::MIE_INC_ACC: begin
                            acc_nxt      = res;
                            flg_nxt.zero = (res == 8'h00);
                        end
                        mie_pkg::MIE_AND_MEM, mie_pkg::MIE_CPL_MEM,
                        mie_pkg::MIE_DEC_MEM, mie_pkg::MIE_INC_MEM: begin
                            we_nxt       = 1'b1;
                            wd_nxt       = res;
                            flg_nxt.zero = (res == 8'h00);
                        end
                        mie_pkg::MIE_CLR_BYTE, mie_pkg::MIE_CLR_BIT: begin
                            we_nxt = 1'b1;
                            wd_nxt = res;
                        end
                        mie_pkg::MIE_DAA: begin
                            we_nxt        = 1'b1;
                            wd_nxt        = res;
                            flg_nxt.carry = daa_c;
                        end
                        mie_pkg::MIE_CALL: begin
                            push_nxt = 1'b1;
                            pdat_nxt = pc_r + mie_pkg::MIE_PC_ONE;
                            pc_nxt   = req_in.target;
                        end
                        mie_pkg::MIE_JMP: begin
                            pc_nxt = req_in.target;
                        end
                        mie_pkg::MIE_WDT_CLR: begin
                            wdt_nxt  = mie_pkg::MIE_BYTE_ZERO;
                            pre_nxt  = mie_pkg::MIE_BYTE_ZERO;
                            pdf_nxt  = 1'b0;
                            to_nxt   = 1'b0;
                        end
                        mie_pkg::MIE_WDT_PRE1, mie_pkg::MIE_WDT_PRE2: begin
                            // Clear only once both halves have run
                            if ((req_in.op == mie_pkg::MIE_WDT_PRE1 && pre2_r) ||
                                (req_in.op == mie_pkg::MIE_WDT_PRE2 && pre1_r)) begin
                                wdt_nxt  = mie_pkg::MIE_BYTE_ZERO;
                                pre_nxt  = mie_pkg::MIE_BYTE_ZERO;
                                pdf_nxt  = 1'b0;
                                to_nxt   = 1'b0;
                                pre1_nxt = 1'b0;
                                pre2_nxt = 1'b0;
                            end else if (req_in.op == mie_pkg::MIE_WDT_PRE1) begin
                                pre1_nxt = 1'b1;
                            end else begin
                                pre2_nxt = 1'b1;
                            end
                        end
                        mie_pkg::MIE_HALT: begin
                            wdt_nxt  = mie_pkg::MIE_BYTE_ZERO;
                            pre_nxt  = mie_pkg::MIE_BYTE_ZERO;
                            pdf_nxt  = 1'b1;
                            to_nxt   = 1'b0;
                            gate_nxt = 1'b1;
                            state_nxt = mie_pkg::MIE_ST_SLEEP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            mie_pkg::MIE_ST_EXEC: begin
                if (cnt_r == 4'h1) begin
                    state_nxt = mie_pkg::MIE_ST_IDLE;
                end
                cnt_nxt = cnt_r - 4'h1;
            end
            mie_pkg::MIE_ST_SLEEP: begin
                // Gate stays shut; core state kept until wake
                if (wake_in) begin
                    gate_nxt  = 1'b0;
                    state_nxt = mie_pkg::MIE_ST_IDLE;
                end
            end
            default: state_nxt = mie_pkg::MIE_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= mie_pkg::MIE_ST_IDLE;
            cnt_r   <= 4'h0;
            acc_r   <= 8'h00;
            flg_r   <= '0;
            we_r    <= 1'b0;
            wd_r    <= 8'h00;
            push_r  <= 1'b0;
            pdat_r  <= mie_pkg::MIE_PC_RST;
            pc_r    <= mie_pkg::MIE_PC_RST;
            pdf_r   <= 1'b0;
            to_r    <= 1'b0;
            wdt_r   <= 8'h00;
            pre_r   <= 8'h00;
            pre1_r  <= 1'b0;
            pre2_r  <= 1'b0;
            gate_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            acc_r   <= acc_nxt;
            flg_r   <= flg_nxt;
            we_r    <= we_nxt;
            wd_r    <= wd_nxt;
            push_r  <= push_nxt;
            pdat_r  <= pdat_nxt;
            pc_r    <= pc_nxt;
            pdf_r   <= pdf_nxt;
            to_r    <= to_nxt;
            wdt_r   <= wdt_nxt;
            pre_r   <= pre_nxt;
            pre1_r  <= pre1_nxt;
            pre2_r  <= pre2_nxt;
            gate_r  <= gate_nxt;
        end
    end

    // Ready is a flop so the decoder sees a clean level
    logic rdy_r;
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rdy_r <= 1'b1;
        end else begin
            rdy_r <= (state_nxt == mie_pkg::MIE_ST_IDLE);
        end
    end

    assign ready_out        = rdy_r;
    assign acc_out          = acc_r;
    assign flags_out        = flg_r;
    assign mem_we_out       = we_r;
    assign mem_wdata_out    = wd_r;
    assign push_out         = push_r;
    assign push_data_out    = pdat_r;
    assign pc_out           = pc_r;
    assign sleep_flag_out   = pdf_r;
    assign expired_flag_out = to_r;
    assign wdt_count_out    = wdt_r;
    assign clk_gate_out     = gate_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_halt_flags;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_HALT) |=>
            (pdf_r && !to_r && gate_r && wdt_r == 8'h00);
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags");

    property p_wdt_clear;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_WDT_CLR) |=>
            (!pdf_r && !to_r && wdt_r == 8'h00);
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("wdt clear");

    property p_pre_single;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_WDT_PRE1 &&
         !pre2_r) |=> (pre1_r && $stable(pdf_r));
    endproperty
    a_pre_single: assert property (p_pre_single) else $error("preclear");

    property p_jump;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_JMP) |=>
            (pc_r == $past(req_in.target) && $stable(flg_r));
    endproperty
    a_jump: assert property (p_jump) else $error("jump");

    property p_call;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_CALL) |=>
            (push_r && pdat_r == $past(pc_r) + 11'h001);
    endproperty
    a_call: assert property (p_call) else $error("call");

    property p_clr_byte;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_CLR_BYTE) |=>
            (we_r && wd_r == 8'h00 && $stable(flg_r));
    endproperty
    a_clr_byte: assert property (p_clr_byte) else $error("clr byte");

    sequence s_long_issue;
        rdy_r && req_valid_in && req_in.pcl_dest;
    endsequence
    property p_pcl_extra;
        @(posedge mclk_in) disable iff (reset_in)
        s_long_issue |=> (!rdy_r) [*7] ##1 rdy_r;
    endproperty
    a_pcl_extra: assert property (p_pcl_extra) else $error("pcl cycles");

    property p_inc_zero;
        @(posedge mclk_in) disable iff (reset_in)
        (rdy_r && req_valid_in && req_in.op == mie_pkg::MIE_INC_ACC) |=>
            (acc_r == $past(req_in.mem) + 8'h01 &&
             flg_r.zero == (acc_r == 8'h00) && $stable(flg_r.carry));
    endproperty
    a_inc_zero: assert property (p_inc_zero) else $error("inc zero");

endmodule

// ===== tb/mie_core_tb.sv
/*
 * Self-checking bench for mie_core: issues decoded operations and
 * compares results, flags, strobes and pacing with a reference model.
 * Assumes mie_pkg is compiled first and a single 50 MHz clock.
 */
`timescale 1ns/100ps
module mie_core_tb;
    logic                mclk_in;
    logic                reset_in;
    logic                req_valid_in;
    mie_pkg::mie_req_t   req_in;
    logic                wdt_tick_in;
    logic                wake_in;
    logic                ready_out;
    logic [7:0]          acc_out;
    mie_pkg::mie_flags_t flags_out;
    logic                mem_we_out;
    logic [7:0]          mem_wdata_out;
    logic                push_out;
    logic [10:0]         push_data_out;
    logic [10:0]         pc_out;
    logic                sleep_flag_out;
    logic                expired_flag_out;
    logic [7:0]          wdt_count_out;
    logic                clk_gate_out;
    int                  mismatches;
    int                  total_checks;
    int                  cycles;
    logic [7:0]          m_acc;
    mie_pkg::mie_flags_t m_fl;
    logic [10:0]         m_pc;
    logic                m_slp;
    logic                p1;
    logic                p2;

    mie_core i_dut (.mclk_in(mclk_in), .reset_in(reset_in),
        .req_valid_in(req_valid_in), .req_in(req_in),
        .wdt_tick_in(wdt_tick_in), .wake_in(wake_in), .ready_out(ready_out),
        .acc_out(acc_out), .flags_out(flags_out), .mem_we_out(mem_we_out),
        .mem_wdata_out(mem_wdata_out), .push_out(push_out),
        .push_data_out(push_data_out), .pc_out(pc_out),
        .sleep_flag_out(sleep_flag_out),
        .expired_flag_out(expired_flag_out),
        .wdt_count_out(wdt_count_out), .clk_gate_out(clk_gate_out));

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    // ****************************************
    // Checking and model
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [11:0] add8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = a + b + ci;
        h = a[3:0] + b[3:0] + ci;
        return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4],
                s[8], s[7:0]};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 70000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // Entered just after an edge that showed ready high
    task automatic run(input mie_pkg::mie_op_t op, input logic [7:0] m,
                       input logic [7:0] x, input logic [2:0] bs,
                       input logic [10:0] tg, input logic program_counter_low_byte);
        logic [11:0] r;
        logic [7:0]  res;
        logic [4:0]  lo;
        logic [4:0]  hi;
        logic [10:0] old;
        logic        to_mem;
        logic        long_op;
        int          n;
        old = m_pc;
        res = m_acc;
        req_in = '{op, m, x, bs, tg, program_counter_low_byte};
        req_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        req_valid_in = 1'b0;
        case (op)
            mie_pkg::MIE_ADC_ACC, mie_pkg::MIE_ADC_MEM, mie_pkg::MIE_ADD_ACC,
            mie_pkg::MIE_ADD_MEM, mie_pkg::MIE_ADD_IMM: begin
                r = add8(m_acc, op == mie_pkg::MIE_ADD_IMM ? x : m,
                         m_fl.carry && (op inside {mie_pkg::MIE_ADC_ACC,
                                                   mie_pkg::MIE_ADC_MEM}));
                res = r[7:0];
                m_fl = r[11:8];
            end
            mie_pkg::MIE_AND_ACC, mie_pkg::MIE_AND_MEM: res = m_acc & m;
            mie_pkg::MIE_AND_IMM:  res = m_acc & x;
            mie_pkg::MIE_CLR_BYTE: res = 8'h00;
            mie_pkg::MIE_CLR_BIT:  res = m & ~(8'h01 << bs);
            mie_pkg::MIE_CPL_MEM, mie_pkg::MIE_CPL_ACC: res = ~m;
            mie_pkg::MIE_DEC_MEM, mie_pkg::MIE_DEC_ACC: res = m - 8'h01;
            mie_pkg::MIE_INC_MEM, mie_pkg::MIE_INC_ACC: res = m + 8'h01;
            mie_pkg::MIE_DAA: begin
                lo = {1'b0, m_acc[3:0]};
                if (lo > 5'h09 || m_fl.half) lo = lo + 5'h06;
                hi = {1'b0, m_acc[7:4]} + {4'h0, lo[4]};
                if (hi > 5'h09 || m_fl.carry) begin
                    hi = hi + 5'h06;
                    m_fl.carry = 1'b1;
                end
                res = {hi[3:0], lo[3:0]};
            end
            mie_pkg::MIE_HALT:    m_slp = 1'b1;
            mie_pkg::MIE_WDT_CLR: m_slp = 1'b0;
            mie_pkg::MIE_WDT_PRE1: p1 = 1'b1;
            mie_pkg::MIE_WDT_PRE2: p2 = 1'b1;
            default: ;
        endcase
        if (p1 && p2) begin
            m_slp = 1'b0;
            p1 = 1'b0;
            p2 = 1'b0;
        end
        if (op inside {[mie_pkg::MIE_AND_ACC:mie_pkg::MIE_AND_MEM],
                       [mie_pkg::MIE_CPL_MEM:mie_pkg::MIE_CPL_ACC],
                       mie_pkg::MIE_DEC_MEM, mie_pkg::MIE_DEC_ACC,
                       mie_pkg::MIE_INC_MEM, mie_pkg::MIE_INC_ACC})
            m_fl.zero = (res == 8'h00);
        if (op inside {mie_pkg::MIE_ADC_ACC, mie_pkg::MIE_ADD_ACC,
                       mie_pkg::MIE_ADD_IMM, mie_pkg::MIE_AND_ACC,
                       mie_pkg::MIE_AND_IMM, mie_pkg::MIE_CPL_ACC,
                       mie_pkg::MIE_DEC_ACC, mie_pkg::MIE_INC_ACC})
            m_acc = res;
        to_mem = op inside {mie_pkg::MIE_ADC_MEM, mie_pkg::MIE_ADD_MEM,
                            mie_pkg::MIE_AND_MEM, mie_pkg::MIE_CLR_BYTE,
                            mie_pkg::MIE_CLR_BIT, mie_pkg::MIE_CPL_MEM,
                            mie_pkg::MIE_DAA, mie_pkg::MIE_DEC_MEM,
                            mie_pkg::MIE_INC_MEM};
        long_op = program_counter_low_byte || (op inside {mie_pkg::MIE_CALL, mie_pkg::MIE_JMP});
        m_pc = (op inside {mie_pkg::MIE_CALL, mie_pkg::MIE_JMP}) ? tg
                                                               : old + 11'h001;
        chk("acc", acc_out, m_acc);
        chk("flags", flags_out, m_fl);
        chk("mem_we", mem_we_out, to_mem);
        if (to_mem) chk("wdata", mem_wdata_out, res);
        chk("push", push_out, op == mie_pkg::MIE_CALL);
        if (op == mie_pkg::MIE_CALL) chk("ret", push_data_out, old + 11'h001);
        if (!program_counter_low_byte) chk("pc", pc_out, m_pc);
        chk("sleep", sleep_flag_out, m_slp);
        chk("expired", expired_flag_out, 1'b0);
        if (op inside {mie_pkg::MIE_HALT, mie_pkg::MIE_WDT_CLR})
            chk("wdt", wdt_count_out, 8'h00);
        n = 1;
        if (op == mie_pkg::MIE_HALT) begin
            chk("gate", clk_gate_out, 1'b1);
            repeat (6) @(posedge mclk_in);
            #1;
            chk("halted", ready_out, 1'b0);
            wake_in = 1'b1;
        end
        while (ready_out !== 1'b1 && n < 40) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        wake_in = 1'b0;
        if (op != mie_pkg::MIE_HALT)
            chk("clocks", 16'(n), long_op ? 16'h8 : 16'h4);
        else
            chk("ungate", clk_gate_out, 1'b0);
        $display("test %s done", op.name());
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {reset_in, req_valid_in, wdt_tick_in, wake_in} = 4'h8;
        req_in = '0;
        {m_acc, m_fl, m_pc, m_slp, p1, p2} = '0;
        repeat (16) @(posedge mclk_in);
        #1;
        reset_in = 1'b0;
        @(posedge mclk_in);
        #1;
        chk("reset", {ready_out, acc_out, flags_out}, 16'h1000);
        chk("reset_pc", pc_out, 11'h000);
        run(mie_pkg::MIE_ADD_IMM, 8'h00, 8'h3f, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADD_ACC, 8'h41, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADC_MEM, 8'h80, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADC_ACC, 8'h0f, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADD_MEM, 8'h70, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_AND_IMM, 8'h00, 8'hff, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_AND_MEM, 8'h0f, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_AND_ACC, 8'h0f, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_CPL_ACC, 8'h6f, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_CPL_MEM, 8'hff, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_INC_ACC, 8'hff, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_INC_MEM, 8'h7f, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_DEC_ACC, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_DEC_MEM, 8'h01, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_CLR_BYTE, 8'ha5, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_CLR_BIT, 8'ha5, 8'h00, 3'h7, 11'h0, 1'b0);
        run(mie_pkg::MIE_CLR_BIT, 8'ha5, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_AND_IMM, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADD_IMM, 8'h00, 8'h9a, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_DAA, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_AND_IMM, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADD_IMM, 8'h00, 8'h09, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_ADD_IMM, 8'h00, 8'h09, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_DAA, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_CALL, 8'h00, 8'h00, 3'h0, 11'h123, 1'b0);
        run(mie_pkg::MIE_CLR_BYTE, 8'h5a, 8'h00, 3'h0, 11'h0, 1'b1);
        run(mie_pkg::MIE_JMP, 8'h00, 8'h00, 3'h0, 11'h456, 1'b0);
        // Run the watchdog past one full wrap so halt has real work to undo
        wdt_tick_in = 1'b1;
        repeat (65792) @(posedge mclk_in);
        #1;
        wdt_tick_in = 1'b0;
        chk("wdt_run", wdt_count_out, 8'h01);
        chk("timeout", expired_flag_out, 1'b1);
        run(mie_pkg::MIE_HALT, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_WDT_PRE1, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_WDT_PRE2, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_HALT, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_WDT_PRE2, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        run(mie_pkg::MIE_WDT_CLR, 8'h00, 8'h00, 3'h0, 11'h0, 1'b0);
        tally_and_finish();
    end
endmodule
